/* rtl/fgm_pkg.sv */
// Package with constants, modes and carrier types of the mode controller
package fgm_pkg;
  localparam int unsigned CLK_HZ = 250000000;
  localparam int unsigned NORMAL_PERIOD_S = 1;
  localparam int unsigned SLEEP_PERIOD_S = 20;
  localparam int unsigned FSLEEP_PERIOD_S = 60;
  localparam int unsigned TICK_HZ = 1000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / TICK_HZ;
  localparam int unsigned NORMAL_TICKS = NORMAL_PERIOD_S * TICK_HZ;
  localparam int unsigned SLEEP_TICKS = SLEEP_PERIOD_S * TICK_HZ;
  localparam int unsigned FSLEEP_TICKS = FSLEEP_PERIOD_S * TICK_HZ;
  localparam int unsigned REST_TIME_S = 1800;
  localparam int unsigned REST_TICKS = REST_TIME_S * TICK_HZ;
  localparam int unsigned IDLE_TIME_S = 10;
  localparam int unsigned IDLE_TICKS = IDLE_TIME_S * TICK_HZ;
  localparam int unsigned LOWV_TIME_S = 10;
  localparam int unsigned LOWV_TICKS = LOWV_TIME_S * TICK_HZ;
  localparam int unsigned CORR_GAP_S = 3600;
  localparam int unsigned CORR_GAP_TICKS = CORR_GAP_S * TICK_HZ;
  localparam int unsigned TBL_DEPTH = 16;
  localparam int unsigned TBL_AW = 4;
  localparam int unsigned TBL_VSHIFT = 12;
  localparam logic [15:0] RATIO_FULL = 16'h2710;

  typedef enum logic [2:0] {
    FGM_NORMAL = 3'h0,
    FGM_FSLEEP = 3'h1,
    FGM_SLEEP = 3'h2,
    FGM_STANDBY = 3'h3,
    FGM_SHUTDOWN = 3'h4,
    FGM_POR = 3'h5
  } fgm_mode_e;

  typedef enum logic [2:0] {
    FGM_CMD_NONE = 3'h0,
    FGM_CMD_NORMAL = 3'h1,
    FGM_CMD_FSLEEP = 3'h2,
    FGM_CMD_SLEEP = 3'h3,
    FGM_CMD_STANDBY = 3'h4,
    FGM_CMD_SHUTDOWN = 3'h5
  } fgm_cmd_e;

  typedef struct packed {
    logic valid;
    logic signed [15:0] current;
    logic [15:0] voltage;
    logic signed [15:0] temp;
  } fgm_meas_s;

  typedef struct packed {
    logic signed [15:0] cur_thresh;
    logic [15:0] low_volt;
    logic signed [15:0] temp_thresh;
    logic [15:0] full_volt;
    logic [31:0] charge_thresh;
    logic use_fsleep;
    logic shutdown_cfg;
    logic hibernate_cfg;
  } fgm_cfg_s;
endpackage

/* rtl/fgm_table.sv */
// Voltage to capacity table memory with registered read data
`timescale 1ns/10ps
module fgm_table
  import fgm_pkg::*;
#(
  parameter int unsigned DEPTH = TBL_DEPTH,
  parameter int unsigned AW = TBL_AW
)
(
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [31:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [31:0] rd_data
);
  logic [31:0] mem [DEPTH];

  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk)
  begin
    rd_data <= mem[rd_addr];
  end
endmodule

/* rtl/fgm_mode_ctrl.sv */
// Fuel gauge power mode sequencer and capacity tracking control
// Functional notes
// - Sample periodically, integrate current into remaining capacity
// - Rested-voltage correction needs all four conditions
// - Correction replaces capacity by table-derived ideal value
// - Recompute full capacity after large rested charge
// - Hold degradation ratio against initial capacity
// - After reset, first voltage sets capacity via table
// - Chip enable low enters shutdown
// - Normal to sleep on low current or command
// - Sleep to normal on current or command
// - Shutdown on low voltage, command, or enable low
// - Standby on low voltage with hibernate, or command
// - Any bus command wakes standby to normal
// - Normal mode cycles every 1 second
// - Full sleep cycles every 60 seconds
// - Sleep cycles every 20 seconds
// - Standby halts processing, keeps state
// - Leaving shutdown restarts through power-on reset
`timescale 1ns/10ps
module fgm_mode_ctrl
  import fgm_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES,
  parameter int unsigned REST_T = REST_TICKS,
  parameter int unsigned IDLE_T = IDLE_TICKS,
  parameter int unsigned LOWV_T = LOWV_TICKS,
  parameter int unsigned GAP_T = CORR_GAP_TICKS,
  parameter int unsigned NORM_T = NORMAL_TICKS,
  parameter int unsigned SLP_T = SLEEP_TICKS,
  parameter int unsigned FSLP_T = FSLEEP_TICKS
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic chip_en,
  input wire logic bus_cmd_seen,
  input wire fgm_cmd_e mode_cmd,
  input wire fgm_cfg_s cfg,
  input wire fgm_meas_s meas,
  input wire logic tbl_wr_en,
  input wire logic [TBL_AW-1:0] tbl_wr_addr,
  input wire logic [31:0] tbl_wr_data,
  input wire logic [31:0] init_full_cap,
  output fgm_mode_e mode,
  output logic meas_req,
  output logic [31:0] remaining_cap,
  output logic [31:0] full_cap,
  output logic [15:0] degrade_ratio,
  output logic corr_done,
  output logic fcc_done
);
  localparam int unsigned CW = 32;

  fgm_mode_e next_mode;
  logic [CW-1:0] div_cnt;
  logic tick;
  logic [CW-1:0] per_cnt;
  logic [CW-1:0] per_lim;
  logic [CW-1:0] idle_cnt;
  logic [CW-1:0] lowv_cnt;
  logic [CW-1:0] rest_cnt;
  logic [CW-1:0] gap_cnt;
  logic cur_low;
  logic volt_low;
  logic idle_done;
  logic lowv_done;
  logic rested;
  logic gap_done;
  logic init_pending;
  logic tbl_wait;
  logic corr_go;
  logic [31:0] tbl_data;
  logic [TBL_AW-1:0] tbl_addr;
  logic [31:0] chg_acc;
  logic chg_armed;
  logic [31:0] cap_before;
  logic fcc_calc;
  logic [63:0] ratio_prod;
  logic gauge_on;
  logic [31:0] cur_ext;
  logic [31:0] abs_cur;
  logic ce_q;

  assign cur_ext = {{16{meas.current[15]}}, meas.current};
  assign abs_cur = meas.current[15] ? 32'(-cur_ext) : cur_ext;
  assign cur_low = $signed(abs_cur) < $signed({{16{1'b0}},
                   cfg.cur_thresh});
  assign volt_low = meas.valid && (meas.voltage < cfg.low_volt);
  assign idle_done = idle_cnt >= CW'(IDLE_T);
  assign lowv_done = lowv_cnt >= CW'(LOWV_T);
  assign rested = rest_cnt >= CW'(REST_T);
  assign gap_done = gap_cnt >= CW'(GAP_T);
  assign gauge_on = (mode == FGM_NORMAL) || (mode == FGM_SLEEP) ||
                    (mode == FGM_FSLEEP);
  assign tbl_addr = meas.voltage[TBL_VSHIFT +: TBL_AW];

  // Divider producing a one-cycle tick enable
  always_ff @(posedge clk)
  begin
    if (sys_rst || div_cnt >= CW'(TICK_DIV - 1))
    begin
      div_cnt <= '0;
    end
    else
    begin
      div_cnt <= div_cnt + 1'b1;
    end
  end
  assign tick = div_cnt == CW'(TICK_DIV - 1);

  // Measurement period per mode
  always_comb
  begin
    unique case (mode)
      FGM_SLEEP: per_lim = CW'(SLP_T);
      FGM_FSLEEP: per_lim = CW'(FSLP_T);
      default: per_lim = CW'(NORM_T);
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst || !gauge_on || mode != next_mode)
    begin
      per_cnt <= '0;
      meas_req <= 1'b0;
    end
    else
    begin
      meas_req <= 1'b0;
      if (tick)
      begin
        if (per_cnt >= per_lim - 1'b1)
        begin
          per_cnt <= '0;
          meas_req <= 1'b1;
        end
        else
        begin
          per_cnt <= per_cnt + 1'b1;
        end
      end
    end
  end

  // Timers for low current, low voltage, rest and correction gap
  always_ff @(posedge clk)
  begin
    if (sys_rst || !gauge_on)
    begin
      idle_cnt <= '0;
      lowv_cnt <= '0;
    end
    else
    begin
      // Idle timer restarts outside normal, so a wake command holds
      if (mode != FGM_NORMAL)
        idle_cnt <= '0;
      else if (tick)
        idle_cnt <= cur_low ? (idle_done ? idle_cnt : idle_cnt + 1'b1) : '0;
      if (tick)
        lowv_cnt <= volt_low ? (lowv_done ? lowv_cnt : lowv_cnt + 1'b1)
                             : '0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst || mode == FGM_POR)
    begin
      rest_cnt <= CW'(REST_T);
      gap_cnt <= CW'(GAP_T);
    end
    else if (corr_done)
    begin
      gap_cnt <= '0;
    end
    else if (tick && gauge_on)
    begin
      rest_cnt <= cur_low ? (rested ? rest_cnt : rest_cnt + 1'b1) : '0;
      gap_cnt <= gap_done ? gap_cnt : gap_cnt + 1'b1;
    end
  end

  // Mode transitions
  always_comb
  begin
    next_mode = mode;
    unique case (mode)
      FGM_POR: next_mode = FGM_NORMAL;
      FGM_NORMAL:
      begin
        if (mode_cmd == FGM_CMD_FSLEEP)
          next_mode = FGM_FSLEEP;
        else if (mode_cmd == FGM_CMD_SLEEP)
          next_mode = FGM_SLEEP;
        else if (idle_done)
          next_mode = cfg.use_fsleep ? FGM_FSLEEP : FGM_SLEEP;
      end
      FGM_SLEEP, FGM_FSLEEP:
      begin
        if (mode_cmd == FGM_CMD_NORMAL || !cur_low)
          next_mode = FGM_NORMAL;
        else if (mode_cmd == FGM_CMD_FSLEEP)
          next_mode = FGM_FSLEEP;
        else if (mode_cmd == FGM_CMD_SLEEP)
          next_mode = FGM_SLEEP;
      end
      FGM_STANDBY:
        if (bus_cmd_seen) next_mode = FGM_NORMAL;
      FGM_SHUTDOWN:
        if (bus_cmd_seen || (chip_en && !ce_q))
          next_mode = FGM_POR;
      default: next_mode = FGM_POR;
    endcase
    if (gauge_on)
    begin
      if (mode_cmd == FGM_CMD_STANDBY)
        next_mode = FGM_STANDBY;
      else if (lowv_done && cfg.hibernate_cfg && !cfg.shutdown_cfg)
        next_mode = FGM_STANDBY;
      if (mode_cmd == FGM_CMD_SHUTDOWN || (lowv_done && cfg.shutdown_cfg))
        next_mode = FGM_SHUTDOWN;
    end
    if (!chip_en)
      next_mode = FGM_SHUTDOWN;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      mode <= FGM_NORMAL;
    else
      mode <= next_mode;
  end

  // Previous enable level; high in reset so reset gives no false release
  always_ff @(posedge clk)
  begin
    ce_q <= sys_rst | chip_en;
  end

  // Capacity table lookup
  fgm_table u_table (
    .clk(clk),
    .wr_en(tbl_wr_en),
    .wr_addr(tbl_wr_addr),
    .wr_data(tbl_wr_data),
    .rd_addr(tbl_addr),
    .rd_data(tbl_data)
  );

  assign corr_go = meas_req && meas.valid && cur_low && rested &&
                   (meas.temp < cfg.temp_thresh) && gap_done;

  // Remaining capacity integration, correction and initialisation
  always_ff @(posedge clk)
  begin
    if (sys_rst || mode == FGM_POR || mode == FGM_SHUTDOWN)
    begin
      remaining_cap <= '0;
      init_pending <= 1'b1;
      tbl_wait <= 1'b0;
      corr_done <= 1'b0;
    end
    else if (gauge_on)
    begin
      corr_done <= 1'b0;
      tbl_wait <= 1'b0;
      if (tbl_wait)
      begin
        remaining_cap <= tbl_data;
        corr_done <= !init_pending;
        init_pending <= 1'b0;
      end
      else if (meas.valid && (init_pending || corr_go))
      begin
        tbl_wait <= 1'b1;
      end
      else if (meas.valid && meas_req)
      begin
        remaining_cap <= 32'(remaining_cap + cur_ext);
      end
    end
  end

  // Full capacity recalculation after a large rested charge
  always_ff @(posedge clk)
  begin
    if (sys_rst || mode == FGM_POR || mode == FGM_SHUTDOWN)
    begin
      chg_acc <= '0;
      chg_armed <= 1'b0;
      cap_before <= '0;
      full_cap <= init_full_cap;
      fcc_calc <= 1'b0;
      fcc_done <= 1'b0;
    end
    else
    begin
      fcc_calc <= 1'b0;
      fcc_done <= fcc_calc;
      if (corr_done && !chg_armed)
      begin
        chg_armed <= 1'b1;
        cap_before <= tbl_data;
        chg_acc <= '0;
      end
      else if (chg_armed && meas_req && meas.valid && !meas.current[15])
      begin
        chg_acc <= 32'(chg_acc + cur_ext);
      end
      if (corr_done && chg_armed && chg_acc > cfg.charge_thresh &&
          meas.voltage >= cfg.full_volt)
      begin
        full_cap <= 32'(full_cap + tbl_data - cap_before -
                        remaining_cap + chg_acc);
        fcc_calc <= 1'b1;
        chg_armed <= 1'b0;
      end
    end
  end

  // Degradation ratio in units of 0.01 percent
  assign ratio_prod = 64'(full_cap) * 64'(RATIO_FULL);

  always_ff @(posedge clk)
  begin
    if (sys_rst || mode == FGM_POR || mode == FGM_SHUTDOWN)
      degrade_ratio <= RATIO_FULL;
    else if (fcc_done && init_full_cap != '0)
      degrade_ratio <= 16'(ratio_prod / 64'(init_full_cap));
  end
endmodule

/* verification/fgm_checker.sv */
// Port checker for the mode controller
`timescale 1ns/10ps
module fgm_checker
  import fgm_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic chip_en,
  input wire logic bus_cmd_seen,
  input wire fgm_cmd_e mode_cmd,
  input wire fgm_mode_e mode,
  input wire logic meas_req,
  input wire logic [31:0] init_full_cap,
  input wire logic [31:0] full_cap,
  input wire logic [31:0] remaining_cap,
  input wire logic [15:0] degrade_ratio
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  function automatic fgm_mode_e want(fgm_cmd_e c);
    case (c)
      FGM_CMD_FSLEEP: return FGM_FSLEEP;
      FGM_CMD_SLEEP: return FGM_SLEEP;
      FGM_CMD_STANDBY: return FGM_STANDBY;
      FGM_CMD_SHUTDOWN: return FGM_SHUTDOWN;
      default: return FGM_NORMAL;
    endcase
  endfunction
  sequence s_wake;
    mode == FGM_SHUTDOWN && chip_en && bus_cmd_seen ##1 chip_en;
  endsequence
  sequence s_restart;
    mode == FGM_POR ##1 mode == FGM_NORMAL;
  endsequence
  property p_ce_low;
    !chip_en |=> mode == FGM_SHUTDOWN;
  endproperty
  property p_cmd;
    mode == FGM_NORMAL && chip_en && mode_cmd != FGM_CMD_NONE
      |=> mode == want($past(mode_cmd));
  endproperty
  property p_sleep_wake;
    (mode == FGM_SLEEP || mode == FGM_FSLEEP) && chip_en
      && mode_cmd == FGM_CMD_NORMAL |=> mode == FGM_NORMAL;
  endproperty
  property p_stby_wake;
    mode == FGM_STANDBY && chip_en && bus_cmd_seen |=> mode == FGM_NORMAL;
  endproperty
  property p_stby_hold;
    mode == FGM_STANDBY && chip_en && !bus_cmd_seen |=> mode == FGM_STANDBY;
  endproperty
  property p_stby_quiet;
    mode == FGM_STANDBY && $past(mode) == FGM_STANDBY |-> !meas_req;
  endproperty
  property p_por;
    s_wake |-> s_restart;
  endproperty
  property p_ce_rise;
    mode == FGM_SHUTDOWN && chip_en && !$past(chip_en) |=> mode == FGM_POR;
  endproperty
  property p_stby_keep;
    mode == FGM_STANDBY && $past(mode) == FGM_STANDBY
      |-> $stable(remaining_cap);
  endproperty
  property p_pulse;
    meas_req |=> !meas_req;
  endproperty
  property p_rst;
    disable iff (1'b0) sys_rst |=> mode == FGM_NORMAL
      && full_cap == init_full_cap && degrade_ratio == RATIO_FULL;
  endproperty
  a_ce_low: assert property (p_ce_low)
    else $error("enable low did not force shutdown");
  a_cmd: assert property (p_cmd)
    else $error("mode command not followed");
  a_sleep_wake: assert property (p_sleep_wake)
    else $error("sleep did not return to normal");
  a_stby_wake: assert property (p_stby_wake)
    else $error("standby did not wake on bus command");
  a_stby_hold: assert property (p_stby_hold)
    else $error("standby left without bus command");
  a_stby_quiet: assert property (p_stby_quiet)
    else $error("measurement started in standby");
  a_por: assert property (p_por)
    else $error("shutdown exit skipped restart");
  a_ce_rise: assert property (p_ce_rise)
    else $error("enable release did not restart");
  a_stby_keep: assert property (p_stby_keep)
    else $error("capacity changed in standby");
  a_pulse: assert property (p_pulse)
    else $error("measurement request longer than one cycle");
  a_rst: assert property (p_rst)
    else $error("reset values wrong");
endmodule

/* verification/fgm_host_model.sv */
// Host model that issues one-cycle bus commands
`timescale 1ns/10ps
module fgm_host_model
  import fgm_pkg::*;
(
  input wire logic clk,
  input wire logic go,
  input wire fgm_cmd_e cmd,
  output logic bus_cmd_seen,
  output fgm_cmd_e mode_cmd
);
  initial
  begin
    bus_cmd_seen = 1'b0;
    mode_cmd = FGM_CMD_NONE;
  end
  // Any bus command addressed to the device, with its decoded mode
  always @(negedge clk)
  begin
    bus_cmd_seen <= go;
    mode_cmd <= go ? cmd : FGM_CMD_NONE;
  end
endmodule

/* verification/tb.sv */
// Self-checking testbench of the mode controller
`timescale 1ns/10ps
module tb
  import fgm_pkg::*;
;
  localparam int TD = 4;
  localparam int NT = 3;
  localparam int ST = 5;
  localparam int FT = 7;
  logic clk;
  logic sys_rst;
  logic chip_en;
  logic go;
  fgm_cmd_e hcmd;
  logic bus_cmd_seen;
  fgm_cmd_e mode_cmd;
  fgm_cfg_s cfg;
  fgm_meas_s meas;
  logic tbl_wr_en;
  logic [TBL_AW-1:0] tbl_wr_addr;
  logic [31:0] tbl_wr_data;
  logic [31:0] init_full_cap;
  fgm_mode_e mode;
  logic meas_req;
  logic [31:0] remaining_cap;
  logic [31:0] full_cap;
  logic [15:0] degrade_ratio;
  logic corr_done;
  logic fcc_done;
  int err_total;
  int checks;
  fgm_mode_ctrl #(.TICK_DIV(TD), .REST_T(4), .IDLE_T(3), .LOWV_T(3),
    .GAP_T(4), .NORM_T(NT), .SLP_T(ST), .FSLP_T(FT)) dut (.clk, .sys_rst,
    .chip_en, .bus_cmd_seen, .mode_cmd, .cfg, .meas, .tbl_wr_en,
    .tbl_wr_addr, .tbl_wr_data, .init_full_cap, .mode, .meas_req,
    .remaining_cap, .full_cap, .degrade_ratio, .corr_done, .fcc_done);
  fgm_host_model host (.clk, .go, .cmd(hcmd), .bus_cmd_seen, .mode_cmd);
  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    if (err_total == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic send(input fgm_cmd_e c);
    go <= 1'b1;
    hcmd <= c;
    @(negedge clk);
    go <= 1'b0;
    @(negedge clk);
  endtask
  task automatic wait_mode(input fgm_mode_e m);
    int n;
    n = 0;
    while (mode !== m && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    chk("mode", 32'(mode), 32'(m));
  endtask
  task automatic t_period(input int exp);
    int n;
    repeat (2)
    begin
      n = 0;
      @(negedge clk);
      while (meas_req !== 1'b1 && n < 400)
      begin
        @(negedge clk);
        n++;
      end
    end
    chk("period", n + 1, exp);
  endtask
  task automatic t_idle;
    wait_mode(FGM_SLEEP);
    t_period(ST * TD);
    send(FGM_CMD_NORMAL);
    chk("wake", 32'(mode), 32'(FGM_NORMAL));
    cfg.use_fsleep = 1'b1;
    wait_mode(FGM_FSLEEP);
    t_period(FT * TD);
    meas.current = 16'sh00c8;
    wait_mode(FGM_NORMAL);
    t_period(NT * TD);
    chk("count", remaining_cap, 32'h0000_1193);
  endtask
  task automatic t_cmds;
    fgm_cmd_e fwd [4] = '{FGM_CMD_FSLEEP, FGM_CMD_SLEEP, FGM_CMD_STANDBY,
      FGM_CMD_SHUTDOWN};
    fgm_mode_e got [4] = '{FGM_FSLEEP, FGM_SLEEP, FGM_STANDBY, FGM_SHUTDOWN};
    fgm_cmd_e back [4] = '{FGM_CMD_NORMAL, FGM_CMD_NORMAL, FGM_CMD_FSLEEP,
      FGM_CMD_NONE};
    for (int i = 0; i < 4; i++)
    begin
      send(fwd[i]);
      chk("cmd", 32'(mode), 32'(got[i]));
      send(back[i]);
      if (i == 3)
      begin
        chk("por", 32'(mode), 32'(FGM_POR));
        @(negedge clk);
      end
      chk("back", 32'(mode), 32'(FGM_NORMAL));
    end
  endtask
  task automatic t_ce;
    chip_en = 1'b0;
    send(FGM_CMD_STANDBY);
    send(FGM_CMD_NORMAL);
    chk("ce low", 32'(mode), 32'(FGM_SHUTDOWN));
    chip_en = 1'b1;
    @(negedge clk);
    chk("ce por", 32'(mode), 32'(FGM_POR));
    @(negedge clk);
    chk("ce back", 32'(mode), 32'(FGM_NORMAL));
  endtask
  task automatic t_lowv(input logic hib);
    cfg.hibernate_cfg = hib;
    cfg.shutdown_cfg = !hib;
    meas.voltage = 16'h0800;
    wait_mode(hib ? FGM_STANDBY : FGM_SHUTDOWN);
    meas.voltage = 16'h3a00;
    send(FGM_CMD_NONE);
    wait_mode(FGM_NORMAL);
    cfg.hibernate_cfg = 1'b0;
    cfg.shutdown_cfg = 1'b0;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    #40000;
    err_total++;
    end_of_test();
  end
  initial
  begin
    err_total = 0;
    checks = 0;
    sys_rst = 1'b1;
    chip_en = 1'b1;
    go = 1'b0;
    hcmd = FGM_CMD_NONE;
    init_full_cap = 32'h0000_8000;
    cfg = '{16'sh0064, 16'h1000, 16'sh0050, 16'hf000, 32'h0001_0000,
      1'b0, 1'b0, 1'b0};
    meas = '{1'b1, 16'sh0000, 16'h3a00, 16'sh0019};
    tbl_wr_en = 1'b0;
    tbl_wr_addr = 4'h0;
    tbl_wr_data = 32'h0;
    for (int i = 0; i < 11; i++)
    begin
      @(negedge clk);
      tbl_wr_en = 1'b1;
      tbl_wr_addr = 4'(i);
      tbl_wr_data = 32'h0000_1000 + 32'(i);
    end
    @(negedge clk);
    sys_rst = 1'b0;
    tbl_wr_en = 1'b0;
    chk("full", full_cap, init_full_cap);
    chk("ratio", 32'(degrade_ratio), 32'h0000_2710);
    repeat (20) @(negedge clk);
    chk("init", remaining_cap, 32'h0000_1003);
    t_idle();
    t_cmds();
    t_ce();
    t_lowv(1'b1);
    t_lowv(1'b0);
    end_of_test();
  end
endmodule
bind fgm_mode_ctrl fgm_checker u_chk (.clk, .sys_rst, .chip_en,
  .bus_cmd_seen, .mode_cmd, .mode, .meas_req, .init_full_cap, .full_cap,
  .remaining_cap, .degrade_ratio);
